// >>> common/lia_pkg.sv
// Constants, encodings and carriers for the local interrupt accept unit
package lia_pkg;
  localparam int AW = 8;
  localparam logic [7:0] REG_CORE_ID = 8'h00;
  localparam logic [7:0] REG_LOG_DEST = 8'h04;
  localparam logic [7:0] REG_DEST_FMT = 8'h08;
  localparam logic [7:0] REG_CTRL = 8'h0c;
  localparam logic [7:0] REG_BCAST = 8'h10;
  localparam logic [7:0] REG_TMR_RELOAD = 8'h14;
  localparam logic [7:0] REG_TMR_CUR = 8'h18;
  localparam logic [7:0] REG_SEND = 8'h1c;
  localparam logic [7:0] REG_IRQ_STAT = 8'h20;
  localparam logic [7:0] REG_IRQ_CLR = 8'h24;
  localparam logic [7:0] REG_IRQ_EN = 8'h28;
  localparam logic [2:0] PAGE_LVT = 3'h2;
  localparam logic [2:0] PAGE_MAP = 3'h4;
  localparam int N_LVT = 6;
  localparam int N_LOC_IN = 5;
  localparam int LVT_VEC_LSB = 0;
  localparam int LVT_KIND_LSB = 8;
  localparam int LVT_STATUS_BIT = 12;
  localparam int LVT_MASK_BIT = 16;
  localparam int LVT_PERIODIC_BIT = 17;
  localparam logic [31:0] LVT_RESET = 32'h0001_0000;
  localparam logic [31:0] LVT_WMASK = 32'h0003_07ff;
  localparam int FMT_FLAT_BIT = 0;
  localparam int CTRL_HWEN_BIT = 0;
  localparam logic FMT_RESET = 1'b1;
  localparam logic HWEN_RESET = 1'b0;
  localparam logic [7:0] BCAST_RESET = 8'hff;
  localparam logic [7:0] CORE_ID_RESET = 8'h00;
  localparam logic [7:0] LOG_DEST_RESET = 8'h00;
  localparam int SEND_DM_BIT = 8;
  localparam int SEND_KIND_LSB = 9;
  localparam int SEND_VEC_LSB = 12;
  localparam int IRQ_W = 5;
  localparam int EV_ACCEPT = 0;
  localparam int EV_IGNORE = 1;
  localparam int EV_MERGE = 2;
  localparam int EV_TIMER = 3;
  localparam int EV_NV = 4;
  localparam logic [7:0] FIRST_QUEUED_VEC = 8'h10;
  localparam logic [2:0] KIND_FIXED = 3'b000;
  localparam logic [2:0] KIND_LOWEST = 3'b001;
  localparam logic [2:0] KIND_SMI = 3'b010;
  localparam logic [2:0] KIND_NMI = 3'b100;
  localparam logic [2:0] KIND_INIT = 3'b101;
  localparam logic [2:0] KIND_STARTUP = 3'b110;
  localparam logic [2:0] KIND_EXT = 3'b111;
  typedef struct packed {
    logic valid;
    logic [7:0] dest;
    logic destination_mode_bit;
    logic [2:0] message_kind_field;
    logic [7:0] vector;
  } int_msg_t;
endpackage

// >>> hdl/local_interrupt_accept_unit.sv
// Per-core local interrupt accept unit with timer and vector table
`timescale 1ns/1ps
module local_interrupt_accept_unit
  import lia_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Register bus
  input wire logic [AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Message network
  input wire int_msg_t msg_in,
  output int_msg_t msg_out,
  // Local sources
  input wire logic [N_LOC_IN-1:0] local_event,
  input wire logic reference_input_clock,
  // Core side
  output logic nv_valid,
  output logic [2:0] nv_kind,
  output logic [7:0] nv_vector,
  output logic irq
);

  logic wait_r;
  logic [31:0] rdata_r;
  logic [7:0] core_id_r;
  logic [7:0] log_dest_r;
  logic fmt_flat_r;
  logic hw_en_r;
  logic [7:0] bcast_r;
  logic [31:0] reload_r;
  logic [31:0] cur_r;
  logic [IRQ_W-1:0] stat_r;
  logic [IRQ_W-1:0] en_r;
  logic irq_r;
  logic [31:0] lvt_r [N_LVT];
  logic [N_LVT-1:0] pend_r;
  logic [255:0] map_r;
  logic [255:0] map_nxt;
  int_msg_t out_r;
  logic nv_valid_r;
  logic [2:0] nv_kind_r;
  logic [7:0] nv_vec_r;
  logic ref_s1, ref_s2, ref_s3;
  logic [N_LOC_IN-1:0] ev_s1, ev_s2, ev_s3;
  logic [31:0] rd_val;
  logic [2:0] loc_sel;

  // Bus decode
  wire req = avs_read | avs_write;
  wire take = req & wait_r;
  wire wr_fire = avs_write & ~wait_r;
  wire [31:0] be_m = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                      {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  wire [31:0] wd = avs_writedata & be_m;
  wire [2:0] page = avs_address[7:5];
  wire [2:0] widx = avs_address[4:2];
  wire hit_lvt = (page == PAGE_LVT) && (widx < 3'(N_LVT));
  wire hit_map = (page == PAGE_MAP);
  wire wr_id = wr_fire && avs_address == REG_CORE_ID;
  wire wr_ld = wr_fire && avs_address == REG_LOG_DEST;
  wire wr_fmt = wr_fire && avs_address == REG_DEST_FMT;
  wire wr_ctrl = wr_fire && avs_address == REG_CTRL;
  wire wr_bc = wr_fire && avs_address == REG_BCAST;
  wire wr_rel = wr_fire && avs_address == REG_TMR_RELOAD;
  wire wr_send = wr_fire && avs_address == REG_SEND;
  wire wr_clr = wr_fire && avs_address == REG_IRQ_CLR;
  wire wr_en = wr_fire && avs_address == REG_IRQ_EN;
  wire wr_map = wr_fire && hit_map;

  function automatic logic [31:0] wmerge(input logic [31:0] old,
                                         input logic [31:0] m);
    wmerge = (old & ~m) | (avs_writedata & m);
  endfunction

  // Destination matching of arriving messages
  wire [7:0] dst = msg_in.dest;
  wire m_bc = dst == bcast_r;
  wire m_phys = ~msg_in.destination_mode_bit && dst == core_id_r;
  wire m_flat = |(dst & log_dest_r);
  wire m_clus = (dst[7:4] == log_dest_r[7:4]) &&
                |(dst[3:0] & log_dest_r[3:0]);
  wire m_log = msg_in.destination_mode_bit &&
               (fmt_flat_r ? m_flat : m_clus);
  wire addressed = msg_in.valid && (m_bc || m_phys || m_log);

  function automatic logic allowed(input logic [2:0] k, input logic en);
    allowed = en || k == KIND_SMI || k == KIND_NMI ||
              k == KIND_INIT || k == KIND_EXT;
  endfunction

  function automatic logic is_nv(input logic [2:0] k);
    is_nv = k == KIND_SMI || k == KIND_NMI || k == KIND_INIT ||
            k == KIND_STARTUP || k == KIND_EXT;
  endfunction

  wire [2:0] mk = msg_in.message_kind_field;
  wire accept = addressed && allowed(mk, hw_en_r);

  // Local source selection, lowest entry first
  always_comb begin
    loc_sel = 3'h0;
    for (int i = N_LVT - 1; i >= 0; i--) begin
      if (pend_r[i]) begin
        loc_sel = 3'(i);
      end
    end
  end

  wire [31:0] loc_e = lvt_r[loc_sel];
  wire [2:0] loc_kind = loc_e[LVT_KIND_LSB +: 3];
  wire [7:0] loc_vec = loc_e[LVT_VEC_LSB +: 8];
  // Arriving messages have no back-pressure, so local ones wait
  wire local_go = ~msg_in.valid && |pend_r;
  // Table entries only carry the four generalized kinds
  wire loc_ok = allowed(loc_kind, hw_en_r) &&
                (loc_kind == KIND_FIXED || loc_kind == KIND_SMI ||
                 loc_kind == KIND_NMI || loc_kind == KIND_EXT);

  // Unified delivery path, arriving fields untouched
  wire del_valid = accept || (local_go && loc_ok);
  wire [2:0] del_kind = msg_in.valid ? mk : loc_kind;
  wire [7:0] del_vec = msg_in.valid ? msg_in.vector : loc_vec;
  wire del_vect = del_kind == KIND_FIXED || del_kind == KIND_LOWEST;
  wire set_vec = del_valid && del_vect &&
                 del_vec >= FIRST_QUEUED_VEC;
  wire nv_fire = del_valid && is_nv(del_kind);
  wire merged = set_vec && map_r[del_vec];

  // Reference clock crossing; each edge is one 2x tick
  wire tick = ref_s2 ^ ref_s3;
  wire periodic = lvt_r[0][LVT_PERIODIC_BIT];
  wire tmr_exp = tick && cur_r == 32'h1 && ~wr_rel;
  wire [N_LOC_IN-1:0] loc_rise = ev_s2 & ~ev_s3;
  wire [N_LVT-1:0] src_evt = {loc_rise, tmr_exp};

  wire [IRQ_W-1:0] evts;
  assign evts[EV_ACCEPT] = del_valid;
  assign evts[EV_IGNORE] = msg_in.valid && ~addressed;
  assign evts[EV_MERGE] = merged;
  assign evts[EV_TIMER] = tmr_exp;
  assign evts[EV_NV] = nv_fire;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ref_s1 <= 1'b0;
      ref_s2 <= 1'b0;
      ref_s3 <= 1'b0;
      ev_s1 <= '0;
      ev_s2 <= '0;
      ev_s3 <= '0;
    end else begin
      ref_s1 <= reference_input_clock;
      ref_s2 <= ref_s1;
      ref_s3 <= ref_s2;
      ev_s1 <= local_event;
      ev_s2 <= ev_s1;
      ev_s3 <= ev_s2;
    end
  end

  // Bus handshake: one wait cycle, then a single-cycle ack
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wait_r <= 1'b1;
      rdata_r <= 32'h0;
    end else begin
      wait_r <= ~take;
      if (take && avs_read) begin
        rdata_r <= rd_val;
      end
    end
  end

  always_comb begin
    rd_val = 32'h0;
    if (hit_map) begin
      rd_val = map_r[32 * widx +: 32];
    end else if (hit_lvt) begin
      rd_val = lvt_r[widx];
      rd_val[LVT_STATUS_BIT] = pend_r[widx];
    end else if (avs_address == REG_CORE_ID) begin
      rd_val = {24'h0, core_id_r};
    end else if (avs_address == REG_LOG_DEST) begin
      rd_val = {24'h0, log_dest_r};
    end else if (avs_address == REG_DEST_FMT) begin
      rd_val = {31'h0, fmt_flat_r};
    end else if (avs_address == REG_CTRL) begin
      rd_val = {31'h0, hw_en_r};
    end else if (avs_address == REG_BCAST) begin
      rd_val = {24'h0, bcast_r};
    end else if (avs_address == REG_TMR_RELOAD) begin
      rd_val = reload_r;
    end else if (avs_address == REG_TMR_CUR) begin
      rd_val = cur_r;
    end else if (avs_address == REG_IRQ_STAT) begin
      rd_val = {{(32 - IRQ_W){1'b0}}, stat_r};
    end else if (avs_address == REG_IRQ_EN) begin
      rd_val = {{(32 - IRQ_W){1'b0}}, en_r};
    end
  end

  // Configuration registers
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      core_id_r <= CORE_ID_RESET;
      log_dest_r <= LOG_DEST_RESET;
      fmt_flat_r <= FMT_RESET;
      hw_en_r <= HWEN_RESET;
      bcast_r <= BCAST_RESET;
      en_r <= '0;
    end else begin
      if (wr_id && avs_byteenable[0]) core_id_r <= wd[7:0];
      if (wr_ld && avs_byteenable[0]) log_dest_r <= wd[7:0];
      if (wr_fmt && avs_byteenable[0]) fmt_flat_r <= wd[FMT_FLAT_BIT];
      if (wr_ctrl && avs_byteenable[0]) hw_en_r <= wd[CTRL_HWEN_BIT];
      if (wr_bc && avs_byteenable[0]) bcast_r <= wd[7:0];
      if (wr_en && avs_byteenable[0]) en_r <= wd[IRQ_W-1:0];
    end
  end

  // Timer; rate tied to the reference clock, not the core clock
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      reload_r <= 32'h0;
      cur_r <= 32'h0;
    end else if (wr_rel) begin
      reload_r <= wmerge(reload_r, be_m);
      cur_r <= wmerge(reload_r, be_m);
    end else if (tmr_exp && periodic) begin
      cur_r <= reload_r;
    end else if (tick && cur_r != 32'h0) begin
      cur_r <= cur_r - 32'h1;
    end
  end

  // Vector table entries and their pending status
  for (genvar g = 0; g < N_LVT; g++) begin : g_lvt
    wire wr_e = wr_fire && hit_lvt && widx == 3'(g);
    wire dlv = local_go && loc_sel == 3'(g);
    wire raise = src_evt[g] && ~lvt_r[g][LVT_MASK_BIT];
    always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
        lvt_r[g] <= LVT_RESET;
        pend_r[g] <= 1'b0;
      end else begin
        if (wr_e) begin
          lvt_r[g] <= wmerge(lvt_r[g], be_m & LVT_WMASK);
        end
        // New event wins over the delivery clear
        pend_r[g] <= raise | (pend_r[g] & ~dlv);
      end
    end
  end

  // Request bitmap; set wins over software clear
  always_comb begin
    map_nxt = map_r;
    if (wr_map) begin
      map_nxt[32 * widx +: 32] = map_r[32 * widx +: 32] & ~wd;
    end
    if (set_vec) begin
      map_nxt[del_vec] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      map_r <= '0;
    end else begin
      map_r <= map_nxt;
    end
  end

  // Non-vectored hand-off, outgoing messages, interrupt status
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      nv_valid_r <= 1'b0;
      nv_kind_r <= 3'h0;
      nv_vec_r <= 8'h0;
      out_r <= '0;
      stat_r <= '0;
      irq_r <= 1'b0;
    end else begin
      nv_valid_r <= nv_fire;
      if (nv_fire) begin
        nv_kind_r <= del_kind;
        nv_vec_r <= del_vec;
      end
      out_r.valid <= wr_send;
      if (wr_send) begin
        out_r.dest <= avs_writedata[7:0];
        out_r.destination_mode_bit <= avs_writedata[SEND_DM_BIT];
        out_r.message_kind_field <= avs_writedata[SEND_KIND_LSB +: 3];
        out_r.vector <= avs_writedata[SEND_VEC_LSB +: 8];
      end
      stat_r <= evts | (stat_r & ~(wr_clr ? wd[IRQ_W-1:0] : '0));
      irq_r <= |(stat_r & en_r);
    end
  end

  assign avs_waitrequest = wait_r;
  assign avs_readdata = rdata_r;
  assign msg_out = out_r;
  assign nv_valid = nv_valid_r;
  assign nv_kind = nv_kind_r;
  assign nv_vector = nv_vec_r;
  assign irq = irq_r;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  sequence s_take;
    req && avs_waitrequest;
  endsequence
  sequence s_ack;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence

  AST_BUS_ACK: assert property (s_take |=> s_ack)
    else $error("bus ack not one cycle after take");
  AST_PHYS: assert property (msg_in.valid && !msg_in.destination_mode_bit
    && dst == core_id_r && mk == KIND_FIXED && hw_en_r
    && msg_in.vector >= FIRST_QUEUED_VEC |=> map_r[$past(msg_in.vector)])
    else $error("physical fixed hit not queued");
  AST_IGNORE: assert property (msg_in.valid && !addressed && !wr_map
    |=> map_r == $past(map_r))
    else $error("ignored message changed bitmap");
  AST_NV_DIRECT: assert property (accept && is_nv(mk)
    && !wr_map |=> nv_valid && nv_kind == $past(mk)
    && map_r == $past(map_r))
    else $error("non-vectored not passed to core");
  AST_RESERVED: assert property (map_r[15:0] == 16'h0)
    else $error("reserved vector queued");
  AST_HW_OFF: assert property (!hw_en_r && msg_in.valid
    && mk == KIND_FIXED && !wr_map |=> map_r == $past(map_r))
    else $error("fixed accepted while disabled");
  AST_BCAST: assert property (msg_in.valid && dst == bcast_r
    && mk == KIND_NMI |=> nv_valid)
    else $error("broadcast not accepted");
  AST_TMR_DEC: assert property (tick && cur_r > 32'h1 && !wr_rel
    |=> cur_r == $past(cur_r) - 32'h1)
    else $error("timer missed a tick");
  AST_TMR_HOLD: assert property (!tick && !wr_rel |=> $stable(cur_r))
    else $error("timer moved without tick");
  AST_CLUSTER: assert property (msg_in.destination_mode_bit && !fmt_flat_r
    && dst[7:4] != log_dest_r[7:4] && !m_bc |-> !addressed)
    else $error("cluster mismatch accepted");
  AST_FLAT: assert property (msg_in.valid && msg_in.destination_mode_bit
    && fmt_flat_r && |(dst & log_dest_r) |-> addressed)
    else $error("flat match refused");
  AST_LOCAL_VEC: assert property (local_go && loc_ok
    && loc_kind == KIND_FIXED && loc_vec >= FIRST_QUEUED_VEC
    |=> map_r[$past(loc_vec)])
    else $error("local vector not queued");
  AST_MERGE: assert property (merged |=> stat_r[EV_MERGE]
    && map_r[$past(del_vec)])
    else $error("merge not flagged");

endmodule

// >>> tb/msg_source.sv
// Behavioural sender standing in for I/O controllers and peer units
`timescale 1ns/1ps
module msg_source
  import lia_pkg::*;
(
  // Clock
  input wire logic clk_sys,
  // Message network
  output int_msg_t msg
);
  initial msg = '0;

  // Kind and vector are sent as given; reserved vectors only when asked
  task automatic send(input logic [7:0] d, input logic dm,
                      input logic [2:0] k, input logic [7:0] v);
    msg <= '{1'b1, d, dm, k, v};
    @(posedge clk_sys);
    // Released fields carry inverted junk, never the last value
    msg <= {1'b0, ~msg[19:0]};
  endtask
endmodule

// >>> tb/local_interrupt_accept_unit_tb.sv
// Self-checking bench for the local interrupt accept unit
`timescale 1ns/1ps
module local_interrupt_accept_unit_tb;
  import lia_pkg::*;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic [AW-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  int_msg_t msg_in;
  int_msg_t msg_out;
  int_msg_t sent_r = '0;
  logic [N_LOC_IN-1:0] local_event = '0;
  logic ref_clk = 1'b0;
  logic nv_valid;
  logic [2:0] nv_kind;
  logic [7:0] nv_vector;
  logic irq;
  logic [31:0] rd;
  logic [31:0] nv_cap;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [2:0] kinds [5] = '{KIND_SMI, KIND_NMI, KIND_INIT, KIND_STARTUP,
                            KIND_EXT};
  // Rows: format, logical destination, destination, vector, expected
  logic [31:0] lg [6] = '{32'h1_24_04_40_1, 32'h1_24_81_41_0,
                          32'h0_32_36_42_1, 32'h0_32_42_43_0,
                          32'h0_32_31_44_0, 32'h1_22_05_45_0};

  always #2.5 clk_sys = ~clk_sys;

  local_interrupt_accept_unit u_local_interrupt_accept_unit (
    .clk_sys(clk_sys), .resetn(resetn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .msg_in(msg_in), .msg_out(msg_out), .local_event(local_event),
    .reference_input_clock(ref_clk), .nv_valid(nv_valid),
    .nv_kind(nv_kind), .nv_vector(nv_vector), .irq(irq));

  msg_source u_msg_source (.clk_sys(clk_sys), .msg(msg_in));

  always @(posedge clk_sys) begin
    if (msg_out.valid === 1'b1)
      sent_r <= msg_out;
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      end_sim();
    end
  end

  task automatic end_sim;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One access; released after the edge that sees waitrequest low
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0) begin
      @(posedge clk_sys);
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, '0);
    check(rd, e);
  endtask

  task automatic bitchk(input logic [7:0] v, input logic e);
    bus(1'b0, 8'h80 + {v[7:5], 2'b00}, '0);
    check({31'h0, rd[v[4:0]]}, {31'h0, e});
  endtask

  // Checks one status bit, then clears all of them
  task automatic statbit(input int b, input logic e);
    bus(1'b0, REG_IRQ_STAT, '0);
    check({31'h0, rd[b]}, {31'h0, e});
    bus(1'b1, REG_IRQ_CLR, 32'h1f);
  endtask

  task automatic snd(input logic [7:0] d, input logic dm,
                     input logic [2:0] k, input logic [7:0] v);
    u_msg_source.send(d, dm, k, v);
    #1;
    nv_cap = {20'h0, nv_valid, nv_kind, nv_vector};
    @(posedge clk_sys);
  endtask

  function automatic logic [31:0] nvx(input logic [2:0] k,
                                      input logic [7:0] v);
    return {20'h0, 1'b1, k, v};
  endfunction

  // Each reference edge is one tick, so two ticks per reference period
  task automatic ref_ticks(input int n);
    repeat (n) begin
      repeat (8) @(posedge clk_sys);
      ref_clk <= ~ref_clk;
    end
    repeat (8) @(posedge clk_sys);
  endtask

  initial begin
    repeat (8) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    rdchk(REG_BCAST, 32'hff);
    rdchk(REG_DEST_FMT, 32'h1);
    rdchk(REG_CTRL, 32'h0);
    rdchk(8'h40, LVT_RESET);
    rdchk(8'h3c, 32'h0);
    snd(8'h00, 1'b0, KIND_FIXED, 8'h30);
    bitchk(8'h30, 1'b0);
    snd(8'h00, 1'b0, KIND_NMI, 8'h31);
    check(nv_cap, nvx(KIND_NMI, 8'h31));
    bus(1'b1, REG_CTRL, 32'h1);
    bus(1'b1, REG_CORE_ID, 32'h05);
    bus(1'b1, REG_IRQ_CLR, 32'h1f);
    snd(8'h05, 1'b0, KIND_FIXED, 8'h31);
    check({31'h0, nv_cap[11]}, 32'h0);
    bitchk(8'h31, 1'b1);
    statbit(EV_ACCEPT, 1'b1);
    snd(8'h06, 1'b0, KIND_FIXED, 8'h32);
    bitchk(8'h32, 1'b0);
    statbit(EV_IGNORE, 1'b1);
    snd(8'h05, 1'b0, KIND_LOWEST, 8'h31);
    statbit(EV_MERGE, 1'b1);
    bitchk(8'h31, 1'b1);
    snd(8'hff, 1'b1, KIND_FIXED, 8'h33);
    bitchk(8'h33, 1'b1);
    bus(1'b1, REG_BCAST, 32'h0f);
    snd(8'h0f, 1'b0, KIND_FIXED, 8'h34);
    bitchk(8'h34, 1'b1);
    snd(8'hff, 1'b0, KIND_FIXED, 8'h35);
    bitchk(8'h35, 1'b0);
    snd(8'h05, 1'b0, KIND_FIXED, 8'h05);
    bitchk(8'h05, 1'b0);
    for (int i = 0; i < 6; i++) begin
      bus(1'b1, REG_DEST_FMT, {31'h0, lg[i][28]});
      bus(1'b1, REG_LOG_DEST, {24'h0, lg[i][27:20]});
      snd(lg[i][19:12], 1'b1, KIND_FIXED, lg[i][11:4]);
      bitchk(lg[i][11:4], lg[i][0]);
    end
    for (int i = 0; i < 5; i++) begin
      snd(8'h05, 1'b0, kinds[i], 8'(8'h50 + i));
      check(nv_cap, nvx(kinds[i], 8'(8'h50 + i)));
      bitchk(8'(8'h50 + i), 1'b0);
    end
    // An accepted INIT only reaches the core outputs; control and core ID are written again anyway
    bus(1'b1, REG_CTRL, 32'h1);
    bus(1'b1, REG_CORE_ID, 32'h05);
    bus(1'b1, 8'h44, 32'h0000_0060);
    local_event[0] <= 1'b1;
    local_event[1] <= 1'b1;
    repeat (6) @(posedge clk_sys);
    bitchk(8'h60, 1'b1);
    bitchk(8'h00, 1'b0);
    bus(1'b1, 8'h40, 32'h0000_0070);
    bus(1'b1, REG_TMR_RELOAD, 32'h4);
    ref_ticks(2);
    rdchk(REG_TMR_CUR, 32'h2);
    ref_ticks(2);
    bitchk(8'h70, 1'b1);
    bus(1'b1, 8'h40, 32'h0002_0074);
    bus(1'b1, REG_TMR_RELOAD, 32'h2);
    ref_ticks(2);
    rdchk(REG_TMR_CUR, 32'h2);
    bitchk(8'h74, 1'b1);
    bus(1'b1, 8'h44, 32'h0000_0462);
    local_event[0] <= 1'b0;
    repeat (4) @(posedge clk_sys);
    local_event[0] <= 1'b1;
    repeat (6) @(posedge clk_sys);
    check({20'h0, 1'b1, nv_kind, nv_vector}, nvx(KIND_NMI, 8'h62));
    bitchk(8'h62, 1'b0);
    bus(1'b1, REG_IRQ_CLR, 32'h1f);
    bus(1'b1, REG_IRQ_EN, 32'h1);
    check({31'h0, irq}, 32'h0);
    snd(8'h05, 1'b0, KIND_FIXED, 8'h71);
    repeat (2) @(posedge clk_sys);
    check({31'h0, irq}, 32'h1);
    bus(1'b1, REG_IRQ_CLR, 32'h1);
    repeat (2) @(posedge clk_sys);
    check({31'h0, irq}, 32'h0);
    rdchk(REG_IRQ_CLR, 32'h0);
    bus(1'b1, REG_IRQ_EN, 32'h0);
    snd(8'h05, 1'b0, KIND_FIXED, 8'h72);
    repeat (2) @(posedge clk_sys);
    check({31'h0, irq}, 32'h0);
    statbit(EV_ACCEPT, 1'b1);
    bus(1'b1, REG_SEND, {12'h0, 8'h66, KIND_FIXED, 1'b1, 8'h0a});
    repeat (3) @(posedge clk_sys);
    check(32'(sent_r), 32'({1'b1, 8'h0a, 1'b1, KIND_FIXED, 8'h66}));
    end_sim();
  end
endmodule
